// File: design/tdf_pkg.sv
// Shared constants, types and register map of the second transmit data link FIFO.
package tdf_pkg;

	// ==========================================================================
	// FIFO geometry
	localparam int unsigned FIFO_DEPTH = 64;
	localparam int unsigned ADDR_W     = 6;
	localparam int unsigned PTR_W      = 7;
	localparam logic [6:0]  COUNT_FULL = 7'h40;

	// ==========================================================================
	// Register indices; byte address is four times the index
	localparam int unsigned PADDR_W      = 10;
	localparam logic [7:0]  IDX_LEVEL    = 8'hb6;
	localparam logic [7:0]  IDX_EOM      = 8'hb7;
	localparam logic [7:0]  IDX_DATA     = 8'hb8;
	localparam logic [7:0]  IDX_STAT     = 8'hb9;
	localparam logic [7:0]  IDX_MODE     = 8'hc0;
	localparam logic [7:0]  IDX_IRQ_STAT = 8'hc1;
	localparam logic [7:0]  IDX_IRQ_CLR  = 8'hc2;
	localparam logic [7:0]  IDX_IRQ_EN   = 8'hc3;

	// ==========================================================================
	// Field positions and reset values
	localparam int unsigned MODE_ENABLE_BIT = 3;
	localparam int unsigned IRQ_NEAR_BIT    = 0;
	localparam int unsigned IRQ_DONE_BIT    = 1;
	localparam int unsigned IRQ_UNDER_BIT   = 2;
	localparam int unsigned IRQ_W           = 3;
	localparam logic [5:0]  LEVEL_RST       = 6'h00;
	localparam logic [2:0]  IRQ_EN_RST      = 3'h0;
	localparam logic        ENABLE_RST      = 1'b0;

	// ==========================================================================
	// Line coding
	localparam logic [7:0] HDLC_FLAG  = 8'h7e;
	localparam logic [7:0] HDLC_ABORT = 8'h7f;
	localparam logic [2:0] STUFF_RUN  = 3'h5;
	localparam logic [3:0] BITS_FULL  = 4'h8;
	localparam logic [3:0] BITS_SIX   = 4'h6;

	typedef enum logic [2:0] {
		MODE_HDLC,
		MODE_EIGHT,
		MODE_SIX,
		MODE_UNFMT,
		MODE_CIRC
	} tdf_mode_e;

	localparam tdf_mode_e MODE_RST = MODE_HDLC;

	typedef struct packed {
		logic message_active_flag;
		logic fifo_empty_flag;
		logic near_empty_flag;
		logic fifo_full_flag;
	} tdf_status_s;

	typedef struct packed {
		logic [7:0] data;
		logic [3:0] bits;
		logic       stuff;
	} tdf_load_s;

endpackage : tdf_pkg

// File: design/tdf_fifo_mem.sv
// Byte storage of the transmit FIFO with a registered read port.
module tdf_fifo_mem
	import tdf_pkg::*;
(
	input  wire logic              clk,
	input  wire logic              reset,
	input  wire logic              wr_en,
	input  wire logic [ADDR_W-1:0] wr_addr,
	input  wire logic [7:0]        wr_data,
	input  wire logic [ADDR_W-1:0] rd_addr,
	output logic      [7:0]        rd_data
);

	logic [7:0] mem [FIFO_DEPTH];
	logic [7:0] rd_data_ff;

	always_ff @(posedge clk)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
	end

	// The read word lags the address by one cycle; the caller waits for it.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			rd_data_ff <= 8'h00;
		end
		else
		begin
			rd_data_ff <= mem[rd_addr];
		end
	end

	assign rd_data = rd_data_ff;

endmodule : tdf_fifo_mem

// File: design/tdf_serializer.sv
// Least significant bit first serializer with optional HDLC zero insertion.
module tdf_serializer
	import tdf_pkg::*;
(
	input  wire logic      clk,
	input  wire logic      reset,
	input  wire logic      bit_en,
	input  wire logic      load,
	input  tdf_pkg::tdf_load_s load_word,
	output logic           ready,
	output logic           tx_bit
);

	logic [7:0] sh_ff;
	logic [3:0] left_ff;
	logic [2:0] ones_ff;
	logic       stuff_ff;
	logic       bit_ff;
	logic       stuff_due;

	assign stuff_due = stuff_ff && (ones_ff == STUFF_RUN);
	// A pending zero after a run of ones must go out before the next byte.
	assign ready     = (left_ff == 4'h0) && !stuff_due;

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			sh_ff    <= 8'h00;
			left_ff  <= 4'h0;
			ones_ff  <= 3'h0;
			stuff_ff <= 1'b0;
			bit_ff   <= 1'b1;
		end
		else if (load)
		begin
			sh_ff    <= load_word.data;
			left_ff  <= load_word.bits;
			stuff_ff <= load_word.stuff;
			if (!load_word.stuff)
			begin
				ones_ff <= 3'h0;
			end
		end
		else if (bit_en)
		begin
			if (stuff_due)
			begin
				bit_ff  <= 1'b0;
				ones_ff <= 3'h0;
			end
			else if (left_ff != 4'h0)
			begin
				bit_ff  <= sh_ff[0];
				sh_ff   <= {1'b0, sh_ff[7:1]};
				left_ff <= left_ff - 4'h1;
				ones_ff <= sh_ff[0] ? ones_ff + 3'h1 : 3'h0;
			end
			else
			begin
				bit_ff <= 1'b1;
			end
		end
	end

	assign tx_bit = bit_ff;

endmodule : tdf_serializer

// File: design/tdf_top.sv
// Transmit FIFO, status and time slot sequencer of the second data link channel.

module tdf_top
	import tdf_pkg::*;
(
	input  wire logic               CORE_CLK,
	input  wire logic               RESET,
	input  wire logic [PADDR_W-1:0] PADDR,
	input  wire logic               PSEL,
	input  wire logic               PENABLE,
	input  wire logic               PWRITE,
	input  wire logic [31:0]        PWDATA,
	output logic      [31:0]        PRDATA,
	output logic                    PREADY,
	output logic                    PSLVERR,
	input  wire logic               TX_BIT_EN,
	output logic                    TX_BIT,
	output tdf_pkg::tdf_status_s    TX_STATUS,
	output logic                    IRQ
);

	import tdf_pkg::*;

	typedef enum logic [1:0] {
		S_IDLE,
		S_DATA,
		S_CLOSE,
		S_ABORT
	} tdf_state_e;

	// ==========================================================================
	// Register bus decode
	logic [7:0]       idx;
	logic             aligned;
	logic             mapped;
	logic             wr_acc;
	logic             wr_level;
	logic             wr_eom;
	logic             wr_data;
	logic             wr_mode;
	logic             wr_irq_clr;
	logic             wr_irq_en;
	logic [31:0]      prdata_ff;
	logic [31:0]      nxt_rdata;

	assign idx     = PADDR[9:2];
	assign aligned = (PADDR[1:0] == 2'h0);
	assign mapped  = aligned && ((idx == IDX_LEVEL) || (idx == IDX_EOM) || (idx == IDX_DATA)
		|| (idx == IDX_STAT) || (idx == IDX_MODE) || (idx == IDX_IRQ_STAT)
		|| (idx == IDX_IRQ_CLR) || (idx == IDX_IRQ_EN));
	assign wr_acc     = PSEL && PENABLE && PWRITE && mapped;
	assign wr_level   = wr_acc && (idx == IDX_LEVEL);
	assign wr_eom     = wr_acc && (idx == IDX_EOM);
	assign wr_data    = wr_acc && (idx == IDX_DATA);
	assign wr_mode    = wr_acc && (idx == IDX_MODE);
	assign wr_irq_clr = wr_acc && (idx == IDX_IRQ_CLR);
	assign wr_irq_en  = wr_acc && (idx == IDX_IRQ_EN);

	assign PREADY  = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA  = prdata_ff;

	// ==========================================================================
	// Configuration registers
	logic [5:0]       level_ff;
	tdf_mode_e        mode_ff;
	logic             enable_ff;
	logic [IRQ_W-1:0] irq_en_ff;

	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			level_ff  <= LEVEL_RST;
			mode_ff   <= MODE_RST;
			enable_ff <= ENABLE_RST;
			irq_en_ff <= IRQ_EN_RST;
		end
		else
		begin
			if (wr_level)
			begin
				level_ff <= PWDATA[5:0];
			end
			if (wr_mode)
			begin
				mode_ff   <= tdf_mode_e'(PWDATA[2:0]);
				enable_ff <= PWDATA[MODE_ENABLE_BIT];
			end
			if (wr_irq_en)
			begin
				irq_en_ff <= PWDATA[IRQ_W-1:0];
			end
		end
	end

	// ==========================================================================
	// FIFO pointers and occupancy
	logic [PTR_W-1:0] wr_ptr_ff;
	logic [PTR_W-1:0] rd_ptr_ff;
	logic [PTR_W-1:0] free_ptr_ff;
	logic [PTR_W-1:0] count;
	logic [ADDR_W-1:0] last_addr;
	logic             full;
	logic             empty;
	logic             push;
	logic             avail;
	logic [7:0]       rd_byte;

	// The free pointer trails the fetch pointer so a circular buffer stays resident.
	assign count     = wr_ptr_ff - free_ptr_ff;
	assign full      = (count == COUNT_FULL);
	assign empty     = (count == 7'h00);
	assign push      = wr_data && !full;
	assign avail     = (rd_ptr_ff != wr_ptr_ff);
	assign last_addr = wr_ptr_ff[ADDR_W-1:0] - 6'h01;

	tdf_fifo_mem u_mem (
		.clk     (CORE_CLK),
		.reset   (RESET),
		.wr_en   (push),
		.wr_addr (wr_ptr_ff[ADDR_W-1:0]),
		.wr_data (PWDATA[7:0]),
		.rd_addr (rd_ptr_ff[ADDR_W-1:0]),
		.rd_data (rd_byte)
	);

	// ==========================================================================
	// End-of-message marks, one per location
	logic [FIFO_DEPTH-1:0] eom_ff;
	logic [PTR_W-1:0]      eom_count_ff;
	logic                  eom_set;
	logic                  eom_consume;
	logic                  cur_eom;

	assign eom_set = wr_eom && !empty && !eom_ff[last_addr];
	assign cur_eom = eom_ff[rd_ptr_ff[ADDR_W-1:0]];

	genvar gi;
	generate
		for (gi = 0; gi < FIFO_DEPTH; gi++)
		begin : g_eom
			always_ff @(posedge CORE_CLK or posedge RESET)
			begin
				if (RESET)
				begin
					eom_ff[gi] <= 1'b0;
				end
				else if (push && (wr_ptr_ff[ADDR_W-1:0] == ADDR_W'(gi)))
				begin
					eom_ff[gi] <= 1'b0;
				end
				else if (eom_set && (last_addr == ADDR_W'(gi)))
				begin
					eom_ff[gi] <= 1'b1;
				end
			end
		end
	endgenerate

	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			eom_count_ff <= 7'h00;
		end
		else if (eom_set && !eom_consume)
		begin
			eom_count_ff <= eom_count_ff + 7'h01;
		end
		else if (eom_consume && !eom_set)
		begin
			eom_count_ff <= eom_count_ff - 7'h01;
		end
	end

	// ==========================================================================
	// Transmit sequencer
	tdf_state_e state_ff;
	tdf_state_e nxt_state;
	tdf_load_s  ld_word;
	logic       ld;
	logic       pop;
	logic       free_adv;
	logic       rewind;
	logic       done_ev;
	logic       under_ev;
	logic       rd_stable_ff;
	logic       ser_ready;

	always_comb
	begin
		nxt_state   = state_ff;
		ld          = 1'b0;
		ld_word     = '{data: HDLC_FLAG, bits: BITS_FULL, stuff: 1'b0};
		pop         = 1'b0;
		free_adv    = 1'b0;
		rewind      = 1'b0;
		eom_consume = 1'b0;
		done_ev     = 1'b0;
		under_ev    = 1'b0;
		if (!enable_ff)
		begin
			nxt_state = S_IDLE;
		end
		else if (ser_ready)
		begin
			case (mode_ff)
				MODE_HDLC:
				begin
					case (state_ff)
						S_IDLE:
						begin
							if (avail)
							begin
								nxt_state = S_DATA;
							end
							else
							begin
								ld = 1'b1;
							end
						end
						S_DATA:
						begin
							if (!avail)
							begin
								ld        = 1'b1;
								ld_word   = '{data: HDLC_ABORT, bits: BITS_FULL, stuff: 1'b0};
								under_ev  = 1'b1;
								nxt_state = S_ABORT;
							end
							else if (rd_stable_ff)
							begin
								ld       = 1'b1;
								ld_word  = '{data: rd_byte, bits: BITS_FULL, stuff: 1'b1};
								pop      = 1'b1;
								free_adv = 1'b1;
								if (cur_eom)
								begin
									eom_consume = 1'b1;
									nxt_state   = S_CLOSE;
								end
							end
						end
						S_CLOSE:
						begin
							ld        = 1'b1;
							done_ev   = 1'b1;
							nxt_state = S_IDLE;
						end
						S_ABORT:
						begin
							ld        = 1'b1;
							nxt_state = S_IDLE;
						end
						default:
						begin
							nxt_state = S_IDLE;
						end
					endcase
				end
				MODE_CIRC:
				begin
					if ((eom_count_ff != 7'h00) && rd_stable_ff)
					begin
						ld      = 1'b1;
						ld_word = '{data: rd_byte, bits: BITS_FULL, stuff: 1'b0};
						if (!cur_eom)
						begin
							pop = 1'b1;
						end
						else if (eom_count_ff > 7'h01)
						begin
							pop         = 1'b1;
							free_adv    = 1'b1;
							eom_consume = 1'b1;
						end
						else
						begin
							rewind = 1'b1;
						end
					end
				end
				MODE_SIX, MODE_EIGHT, MODE_UNFMT:
				begin
					if (avail && rd_stable_ff)
					begin
						ld       = 1'b1;
						ld_word  = '{data: rd_byte, bits: (mode_ff == MODE_SIX) ? BITS_SIX : BITS_FULL,
							stuff: 1'b0};
						pop      = 1'b1;
						free_adv = 1'b1;
					end
				end
				default:
				begin
					nxt_state = S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			state_ff     <= S_IDLE;
			wr_ptr_ff    <= 7'h00;
			rd_ptr_ff    <= 7'h00;
			free_ptr_ff  <= 7'h00;
			rd_stable_ff <= 1'b0;
		end
		else
		begin
			state_ff     <= wr_mode ? S_IDLE : nxt_state;
			// A byte written at the fetch address reaches the read register a cycle late.
			rd_stable_ff <= !(pop || rewind || wr_mode || (push && (wr_ptr_ff == rd_ptr_ff)));
			if (push)
			begin
				wr_ptr_ff <= wr_ptr_ff + 7'h01;
			end
			// A mode change drops any replay position back to the oldest held byte.
			if (wr_mode || rewind)
			begin
				rd_ptr_ff <= free_ptr_ff;
			end
			else if (pop)
			begin
				rd_ptr_ff <= rd_ptr_ff + 7'h01;
			end
			if (free_adv && !wr_mode)
			begin
				free_ptr_ff <= rd_ptr_ff + 7'h01;
			end
		end
	end

	tdf_serializer u_ser (
		.clk       (CORE_CLK),
		.reset     (RESET),
		.bit_en    (TX_BIT_EN),
		.load      (ld),
		.load_word (ld_word),
		.ready     (ser_ready),
		.tx_bit    (TX_BIT)
	);

	// ==========================================================================
	// Status and interrupts
	tdf_status_s      status;
	logic             below;
	logic             below_prev_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_ev;

	assign below = (level_ff != 6'h00) && (count < {1'b0, level_ff});
	assign status.message_active_flag = (mode_ff != MODE_HDLC)
		|| (state_ff == S_DATA) || (state_ff == S_CLOSE);
	assign status.fifo_empty_flag     = empty;
	assign status.near_empty_flag     = below;
	assign status.fifo_full_flag      = full;
	assign TX_STATUS = status;

	always_comb
	begin
		irq_ev                = '0;
		irq_ev[IRQ_NEAR_BIT]  = below && !below_prev_ff;
		irq_ev[IRQ_DONE_BIT]  = done_ev;
		irq_ev[IRQ_UNDER_BIT] = under_ev;
	end

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			irq_stat_ff   <= '0;
			below_prev_ff <= 1'b0;
		end
		else
		begin
			below_prev_ff <= below;
			irq_stat_ff   <= (irq_stat_ff & ~(wr_irq_clr ? PWDATA[IRQ_W-1:0] : 3'h0)) | irq_ev;
		end
	end

	assign IRQ = |(irq_stat_ff & irq_en_ff);

	// ==========================================================================
	// Read data, captured in the setup phase
	always_comb
	begin
		nxt_rdata = 32'h0000_0000;
		case (idx)
			IDX_LEVEL:    nxt_rdata = {26'h000_0000, level_ff};
			IDX_STAT:     nxt_rdata = {28'h000_0000, status};
			IDX_MODE:     nxt_rdata = {28'h000_0000, enable_ff, mode_ff};
			IDX_IRQ_STAT: nxt_rdata = {29'h000_0000, irq_stat_ff};
			IDX_IRQ_EN:   nxt_rdata = {29'h000_0000, irq_en_ff};
			default:      nxt_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			prdata_ff <= 32'h0000_0000;
		end
		else if (PSEL && !PENABLE && !PWRITE)
		begin
			prdata_ff <= (mapped && aligned) ? nxt_rdata : 32'h0000_0000;
		end
	end

endmodule : tdf_top

// File: test/tdf_top_props.sv
// Port-level checker of the second transmit link FIFO, bound to its top module.
module tdf_top_props
	import tdf_pkg::*;
(
	input wire logic                       CORE_CLK,
	input wire logic                       RESET,
	input wire logic [tdf_pkg::PADDR_W-1:0] PADDR,
	input wire logic                       PSEL,
	input wire logic                       PENABLE,
	input wire logic                       PWRITE,
	input wire logic [31:0]                PWDATA,
	input wire logic [31:0]                PRDATA,
	input wire logic                       PREADY,
	input wire logic                       PSLVERR,
	input wire logic                       TX_BIT_EN,
	input wire logic                       TX_BIT,
	input tdf_pkg::tdf_status_s            TX_STATUS,
	input wire logic                       IRQ
);
	// ==========================================================================
	// Shadow copies of what software has programmed
	logic [5:0] level_ff;
	logic [2:0] irq_en_ff;
	logic [7:0] idx;
	logic       acc;
	logic       dwr;
	assign idx = PADDR[9:2];
	assign acc = PSEL && PENABLE;
	assign dwr = acc && PWRITE && idx == IDX_DATA;
	always_ff @(posedge CORE_CLK or posedge RESET)
	begin
		if (RESET)
		begin
			level_ff  <= 6'h00;
			irq_en_ff <= 3'h0;
		end
		else if (acc && PWRITE && idx == IDX_LEVEL)
			level_ff <= PWDATA[5:0];
		else if (acc && PWRITE && idx == IDX_IRQ_EN)
			irq_en_ff <= PWDATA[2:0];
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (RESET);
	// ==========================================================================
	// Assertions
	unmapped_err_a: assert property (acc && !(idx inside {[IDX_LEVEL:IDX_STAT],
		[IDX_MODE:IDX_IRQ_EN]}) |-> PSLVERR) else $error("unmapped access without error");
	wo_read_zero_a: assert property (acc && !PWRITE && (idx == IDX_EOM || idx == IDX_DATA)
		|-> PRDATA == 32'h0) else $error("write-only register read not zero");
	level_read_a: assert property (acc && !PWRITE && idx == IDX_LEVEL
		|-> PRDATA == {26'h0, level_ff}) else $error("level read differs from written");
	status_read_a: assert property (acc && !PWRITE && idx == IDX_STAT
		|-> PRDATA == {28'h0, $past(TX_STATUS)}) else $error("status read differs from pins");
	full_excl_a: assert property (TX_STATUS.fifo_full_flag
		|-> !TX_STATUS.fifo_empty_flag && !TX_STATUS.near_empty_flag) else $error("full clash");
	near_off_a: assert property (level_ff == 6'h00 |-> !TX_STATUS.near_empty_flag)
		else $error("near-empty while threshold disabled");
	empty_near_a: assert property (TX_STATUS.fifo_empty_flag && level_ff != 6'h00
		|-> TX_STATUS.near_empty_flag) else $error("empty fifo not near-empty");
	full_rise_a: assert property ($rose(TX_STATUS.fifo_full_flag) |-> $past(dwr))
		else $error("full rose without a data write");
	empty_fall_a: assert property ($fell(TX_STATUS.fifo_empty_flag) |-> $past(dwr))
		else $error("empty fell without a data write");
	bit_step_a: assert property ($changed(TX_BIT) |-> $past(TX_BIT_EN))
		else $error("line bit moved without a strobe");
	irq_mask_a: assert property (irq_en_ff == 3'h0 |-> !IRQ)
		else $error("interrupt while all sources masked");
endmodule : tdf_top_props

bind tdf_top tdf_top_props props (.CORE_CLK(CORE_CLK), .RESET(RESET), .PADDR(PADDR),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .TX_BIT_EN(TX_BIT_EN), .TX_BIT(TX_BIT),
	.TX_STATUS(TX_STATUS), .IRQ(IRQ));

// File: test/tdf_link_model.sv
// Framer time slot model: strobes line bits and collects them least significant first.
module tdf_link_model
(
	input  wire logic  clk,
	input  wire logic  reset,
	input  wire logic  run,
	input  wire logic  slow,
	input  wire logic  tx_bit,
	output logic       tx_bit_en,
	output logic [31:0] hist,
	output int         nbits
);
	// ==========================================================================
	// Strobe sequencer
	logic [2:0]  phase_ff;
	logic        en_ff;
	logic [31:0] hist_ff;
	int          nbits_ff;
	assign tx_bit_en = en_ff;
	assign hist = hist_ff;
	assign nbits = nbits_ff;
	// Strobes stay at least four cycles apart so every byte fetch completes in time.
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset || !run)
		begin
			phase_ff <= 3'h0;
			en_ff    <= 1'b0;
			nbits_ff <= 0;
		end
		else
		begin
			phase_ff <= (phase_ff == (slow ? 3'h7 : 3'h3)) ? 3'h0 : phase_ff + 3'h1;
			en_ff    <= phase_ff == 3'h1;
			if (phase_ff == 3'h3)
			begin
				hist_ff  <= {tx_bit, hist_ff[31:1]};
				nbits_ff <= nbits_ff + 1;
			end
		end
	end
endmodule : tdf_link_model

// File: test/tdf_top_bench.sv
// Self-checking bench of the second transmit link FIFO.
module tdf_top_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import tdf_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        psel = 1'b0;
	logic        pen = 1'b0;
	logic        pwr = 1'b0;
	logic        run = 1'b0;
	logic        slow = 1'b0;
	logic        saw_act = 1'b0;
	logic        err;
	logic [9:0]  paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        bit_en;
	logic        tx_bit;
	logic        irq;
	logic [31:0] hist;
	int          nbits;
	int          n_fail = 0;
	int          tests_run = 0;
	tdf_status_s st;

	always #25 clk = ~clk;
	always @(posedge clk) saw_act <= run && (saw_act || st.message_active_flag === 1'b1);

	tdf_top dut (.CORE_CLK(clk), .RESET(rst), .PADDR(paddr), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.TX_BIT_EN(bit_en), .TX_BIT(tx_bit), .TX_STATUS(st), .IRQ(irq));
	tdf_link_model link (.clk(clk), .reset(rst), .run(run), .slow(slow), .tx_bit(tx_bit),
		.tx_bit_en(bit_en), .hist(hist), .nbits(nbits));

	// ==========================================================================
	// Shared tasks
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task apb(input logic [7:0] i, input logic w, input logic [31:0] d);
		@(posedge clk);
		psel   <= 1'b1;
		pen    <= 1'b0;
		pwr    <= w;
		paddr  <= {i, 2'b00};
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen  <= 1'b0;
		#1;
	endtask : apb
	task rdc(input string nm, input logic [7:0] i, input logic [31:0] exp);
		apb(i, 1'b0, 32'h0);
		chk(nm, rd, exp);
	endtask : rdc
	task wait_bits(input int n);
		for (int k = 0; k < 4000 && nbits < n; k++)
			@(posedge clk);
	endtask : wait_bits
	task seek(input logic [7:0] b);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < 3000 && !hit; k++)
		begin
			@(posedge clk);
			hit = (hist[31:24] === b);
		end
		chk("line byte", {31'h0, hit}, 32'h1);
	endtask : seek
	task stop_test;
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : stop_test

	// ==========================================================================
	// Scenarios
	task t_reset;
		chk("status pins", {28'h0, st}, 32'h4);
		chk("idle bit", {31'h0, tx_bit}, 32'h1);
		rdc("status reg", IDX_STAT, 32'h4);
		rdc("level reg", IDX_LEVEL, 32'h0);
		apb(8'hba, 1'b0, 32'h0);
		chk("unmapped err", {31'h0, err}, 32'h1);
		apb(IDX_LEVEL, 1'b1, 32'hff);
		rdc("level mask", IDX_LEVEL, 32'h3f);
		apb(IDX_EOM, 1'b1, 32'ha5);
		rdc("eom read", IDX_EOM, 32'h0);
		$display("test reset done");
	endtask : t_reset
	task t_fill;
		apb(IDX_LEVEL, 1'b1, 32'h5);
		apb(IDX_IRQ_EN, 1'b1, 32'h1);
		chk("near irq pin", {31'h0, irq}, 32'h1);
		apb(IDX_IRQ_CLR, 1'b1, 32'h7);
		chk("irq cleared", {31'h0, irq}, 32'h0);
		for (int k = 0; k < 64; k++)
		begin
			apb(IDX_DATA, 1'b1, 32'(k));
			if (k == 3)
				chk("near held", {31'h0, st.near_empty_flag}, 32'h1);
			if (k == 4)
				chk("near gone", {31'h0, st.near_empty_flag}, 32'h0);
		end
		apb(IDX_DATA, 1'b1, 32'hee);
		rdc("full status", IDX_STAT, 32'h1);
		apb(IDX_MODE, 1'b1, 32'hb);
		@(posedge clk);
		run <= 1'b1;
		for (int k = 0; k < 64; k++)
		begin
			wait_bits(8 * (k + 1));
			chk("unformatted byte", {24'h0, hist[31:24]}, 32'(k));
		end
		chk("active unformatted", {31'h0, st.message_active_flag}, 32'h1);
		rdc("drained status", IDX_STAT, 32'he);
		apb(IDX_IRQ_STAT, 1'b0, 32'h0);
		chk("near irq event", rd & 32'h1, 32'h1);
		@(posedge clk);
		run <= 1'b0;
		apb(IDX_MODE, 1'b1, 32'h0);
		$display("test fill and drain done");
	endtask : t_fill
	task t_six;
		apb(IDX_DATA, 1'b1, 32'hc5);
		apb(IDX_DATA, 1'b1, 32'h3a);
		apb(IDX_MODE, 1'b1, 32'ha);
		@(posedge clk);
		slow <= 1'b1;
		run  <= 1'b1;
		wait_bits(12);
		chk("six bit pack", {20'h0, hist[31:20]}, {20'h0, 6'h3a, 6'h05});
		@(posedge clk);
		run  <= 1'b0;
		slow <= 1'b0;
		apb(IDX_MODE, 1'b1, 32'h0);
		$display("test six-bit done");
	endtask : t_six
	task t_hdlc;
		apb(IDX_MODE, 1'b1, 32'h8);
		@(posedge clk);
		run <= 1'b1;
		apb(IDX_DATA, 1'b1, 32'h0f);
		apb(IDX_EOM, 1'b1, 32'h0);
		apb(IDX_DATA, 1'b1, 32'h33);
		apb(IDX_EOM, 1'b1, 32'h0);
		seek(8'h0f);
		seek(8'h33);
		for (int k = 0; k < 300 && st.message_active_flag !== 1'b0; k++)
			@(posedge clk);
		chk("active seen", {31'h0, saw_act}, 32'h1);
		rdc("hdlc idle", IDX_STAT, 32'h6);
		apb(IDX_IRQ_STAT, 1'b0, 32'h0);
		chk("done irq", rd & 32'h2, 32'h2);
		apb(IDX_DATA, 1'b1, 32'h0f);
		seek(8'h7f);
		apb(IDX_IRQ_STAT, 1'b0, 32'h0);
		chk("underrun irq", rd & 32'h4, 32'h4);
		apb(IDX_IRQ_EN, 1'b1, 32'h0);
		chk("irq masked", {31'h0, irq}, 32'h0);
		$display("test hdlc done");
	endtask : t_hdlc
	task t_circ;
		int n;
		apb(IDX_MODE, 1'b1, 32'h9);
		apb(IDX_DATA, 1'b1, 32'h96);
		seek(8'h96);
		chk("active eight", {31'h0, st.message_active_flag}, 32'h1);
		apb(IDX_MODE, 1'b1, 32'hc);
		apb(IDX_DATA, 1'b1, 32'ha1);
		apb(IDX_DATA, 1'b1, 32'hb2);
		apb(IDX_EOM, 1'b1, 32'h0);
		seek(8'hb2);
		n = nbits;
		wait_bits(n + 16);
		chk("circ replay", {16'h0, hist[31:16]}, 32'hb2a1);
		chk("active circ", {31'h0, st.message_active_flag}, 32'h1);
		apb(IDX_DATA, 1'b1, 32'hc3);
		apb(IDX_EOM, 1'b1, 32'h0);
		seek(8'hc3);
		chk("circ switch", {16'h0, hist[31:16]}, 32'hc3b2);
		n = nbits;
		wait_bits(n + 8);
		chk("circ new replay", {24'h0, hist[31:24]}, 32'hc3);
		@(posedge clk);
		run <= 1'b0;
		apb(IDX_MODE, 1'b1, 32'h0);
		$display("test circular done");
	endtask : t_circ

	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_fill;
		t_six;
		t_hdlc;
		t_circ;
		stop_test;
	end
	initial
	begin
		repeat (40000) @(posedge clk);
		n_fail++;
		stop_test;
	end
endmodule : tdf_top_bench
